//--- hw/ata_cmd_map.svh
/*
 * Task-file offsets, opcodes, subcommand codes, field positions and reset values of the command handler.
 * Assumes it is included by bare name from the package, the command handler and the testbench.
 */
`ifndef ATA_CMD_MAP_SVH
`define ATA_CMD_MAP_SVH

`define TF_DATA          3'h0
`define TF_FEATURE       3'h1
`define TF_SECCOUNT      3'h2
`define TF_SECNUM        3'h3
`define TF_CYL_LO        3'h4
`define TF_CYL_HI        3'h5
`define TF_DEVHEAD       3'h6
`define TF_COMMAND       3'h7

`define OP_SET_MAX       8'hf9
`define OP_SET_MULT      8'hc6
`define OP_SLEEP_A       8'he6
`define OP_SLEEP_B       8'h99
`define OP_SMART         8'hb0

`define SMART_KEY_LO     8'h4f
`define SMART_KEY_HI     8'hc2
`define SUB_READ_VALUES  8'hd0
`define SUB_READ_THRESH  8'hd1
`define SUB_FIRST        8'hd0
`define SUB_LAST_LOW     8'hd6
`define SUB_FIRST_HIGH   8'hd8
`define SUB_LAST         8'hdb
`define SUB_READ_LOG     8'hd5
`define SUB_WRITE_LOG    8'hd6

`define DH_LBA_BIT       6
`define DH_DEV_BIT       4
`define ERR_ABORT_BIT    2

`define CHS_MAX_SECTOR   8'h3f
`define CHS_MAX_HEAD     4'hf

`define BLOCK_RESET      5'h00
`define BLOCK_2          5'h02
`define BLOCK_4          5'h04
`define BLOCK_8          5'h08
`define BLOCK_16         5'h10

`define XFER_LAST        8'hff
`define BYTE_ZERO        8'h00
`define WORD_ZERO        16'h0000

`endif

//--- hw/ata_cmd_pkg.sv
/*
 * Types shared by the command handler: task-file address and the one-hot control states.
 * Assumes the map header is on the include path.
 */
`include "ata_cmd_map.svh"

package ata_cmd_pkg;

    typedef logic [2:0] reg_addr_t;

    typedef enum logic [5:0] {
        st_idle  = 6'h01,
        st_flush = 6'h02,
        st_spin  = 6'h04,
        st_sleep = 6'h08,
        st_work  = 6'h10,
        st_xfer  = 6'h20
    } state_t;

endpackage : ata_cmd_pkg

//--- hw/ata_command_handler.sv
/*
 * Task-file command handler: set-max-address return, block size, sleep and self-monitoring dispatch.
 * Assumes synchronous host strobes, a media engine answering its requests, and an attribute source.
 */
// Behaviour
// - Addressing bit picks sector or block addressing.
// - Drive bit picks master or slave drive.
// - Block mode returns max address across four fields.
// - Sector mode returns cylinder, sector 63, head 15.
// - Opcode C6h sets block size from count.
// - Hardware reset leaves block size zero, multiple disabled.
// - Only sizes 0,2,4,8,16; zero disables.
// - Invalid size aborts and disables multiple.
// - Only sleep opcodes enter sleep.
// - Sleep flushes cache, interrupts, then spins down.
// - Only software or hardware reset leaves sleep.
// - Already spun down skips spin down.
// - Device decodes the listed monitoring subcommands.
// - Attribute read: busy, save, data request, interrupt.
// - Threshold read: busy, fetch, data request, interrupt.
`timescale 1ns/10ps
`default_nettype none
`include "ata_cmd_map.svh"

module ata_command_handler (
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic                  is_slave,
    input  wire logic                  host_wr,
    input  wire logic                  host_rd,
    input  wire ata_cmd_pkg::reg_addr_t host_addr,
    input  wire logic [7:0]            host_wdata,
    output logic      [15:0]           host_rdata,
    input  wire logic                  soft_reset,
    output logic                       intrq,
    output logic                       multiple_enabled,
    output logic      [4:0]            block_size,
    output logic                       flush_req,
    input  wire logic                  flush_done,
    output logic                       spin_req,
    input  wire logic                  spun_down,
    output logic                       media_req,
    output logic                       media_kind,
    input  wire logic                  media_done,
    input  wire logic [27:0]           max_lba,
    input  wire logic [15:0]           max_cyl,
    input  wire logic                  attr_valid,
    output logic                       attr_ready,
    input  wire logic [15:0]           attr_data
);
    import ata_cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Task-file state.

    state_t      state;
    state_t      next_state;
    logic [7:0]  feature;
    logic [7:0]  seccount;
    logic [7:0]  secnum;
    logic [7:0]  cyl_lo;
    logic [7:0]  cyl_hi;
    logic [7:0]  devhead;
    logic        abort_error_flag;
    logic        next_abort;
    logic [7:0]  word_count;
    logic        fifo_valid;
    logic [15:0] fifo_data;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode.

    wire        sleeping       = (state == st_sleep);
    wire        idle           = (state == st_idle);
    wire        busy           = (state == st_flush) || (state == st_spin) || (state == st_work);
    wire        drq            = (state == st_xfer);
    wire        dev_match      = (devhead[`DH_DEV_BIT] == is_slave);
    wire        lba_mode       = devhead[`DH_LBA_BIT];
    wire        tf_wr          = host_wr && !sleeping && idle;
    wire        cmd_wr         = tf_wr && dev_match && (host_addr == `TF_COMMAND);
    wire [7:0]  opcode         = host_wdata;
    wire        op_set_max     = cmd_wr && (opcode == `OP_SET_MAX);
    wire        op_set_mult    = cmd_wr && (opcode == `OP_SET_MULT);
    wire        op_sleep       = cmd_wr && ((opcode == `OP_SLEEP_A) || (opcode == `OP_SLEEP_B));
    wire        op_smart       = cmd_wr && (opcode == `OP_SMART);
    wire        op_other       = cmd_wr && !op_set_max && !op_set_mult && !op_sleep && !op_smart;
    wire        size_ok        = (seccount == {3'h0, `BLOCK_RESET}) || (seccount == {3'h0, `BLOCK_2}) ||
                                 (seccount == {3'h0, `BLOCK_4}) || (seccount == {3'h0, `BLOCK_8}) ||
                                 (seccount == {3'h0, `BLOCK_16});
    wire        key_ok         = (cyl_lo == `SMART_KEY_LO) && (cyl_hi == `SMART_KEY_HI);
    wire        sub_listed     = ((feature >= `SUB_FIRST) && (feature <= `SUB_LAST_LOW)) ||
                                 ((feature >= `SUB_FIRST_HIGH) && (feature <= `SUB_LAST));
    wire        sub_read       = (feature == `SUB_READ_VALUES) || (feature == `SUB_READ_THRESH);
    wire        sub_log        = (feature == `SUB_READ_LOG) || (feature == `SUB_WRITE_LOG);
    wire        smart_read     = op_smart && key_ok && sub_read;
    wire        smart_plain    = op_smart && key_ok && sub_listed && !sub_read && !sub_log;
    wire        smart_bad      = op_smart && !smart_read && !smart_plain;
    wire        flush_end      = (state == st_flush) && flush_done;
    wire        data_pop       = drq && host_rd && (host_addr == `TF_DATA) && fifo_valid;
    wire        xfer_end       = data_pop && (word_count == `XFER_LAST);
    wire        irq_set        = op_set_max || op_set_mult || op_other || op_smart && !smart_read ||
                                 flush_end || ((state == st_work) && media_done);
    wire        irq_clr        = cmd_wr || (host_rd && (host_addr == `TF_COMMAND)) || soft_reset;
    wire        seek_complete_flag  = !sleeping;
    wire        corrected_data_flag = 1'b0;
    wire        index_flag          = 1'b0;
    wire [7:0]  error_reg      = {5'h00, abort_error_flag, 2'h0};
    wire [7:0]  status_reg     = {busy, !busy && !sleeping, 1'b0, seek_complete_flag, drq,
                                  corrected_data_flag, index_flag, abort_error_flag};

    assign flush_req        = (state == st_flush);
    assign spin_req         = (state == st_spin);
    assign media_req        = (state == st_work);
    assign multiple_enabled = (block_size != `BLOCK_RESET);

    ////////////////////////////////////////////////////////////////////////////////
    // Control state machine.

    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: begin
                // sleep entry only on sleep opcodes.
                if (op_sleep) begin
                    next_state = st_flush;
                end else if (smart_read) begin
                    next_state = st_work;
                end
            end
            st_flush: begin
                // flush, then interrupt; skip spin when already down.
                if (flush_done) begin
                    next_state = spun_down ? st_sleep : st_spin;
                end
            end
            st_spin: begin
                if (spun_down) begin
                    next_state = st_sleep;
                end
            end
            st_sleep: begin
                next_state = st_sleep;
            end
            st_work: begin
                // busy until the media work ends, then data request.
                if (media_done) begin
                    next_state = st_xfer;
                end
            end
            st_xfer: begin
                if (xfer_end) begin
                    next_state = st_idle;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst || soft_reset) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Task-file registers.

    always_ff @(posedge clock) begin
        if (!nrst) begin
            feature  <= `BYTE_ZERO;
            seccount <= `BYTE_ZERO;
        end else if (tf_wr && host_addr == `TF_FEATURE) begin
            feature  <= host_wdata;
        end else if (tf_wr && host_addr == `TF_SECCOUNT) begin
            seccount <= host_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            secnum  <= `BYTE_ZERO;
            cyl_lo  <= `BYTE_ZERO;
            cyl_hi  <= `BYTE_ZERO;
            devhead <= `BYTE_ZERO;
        end else if (op_set_max && lba_mode) begin
            secnum       <= max_lba[7:0];
            cyl_lo       <= max_lba[15:8];
            cyl_hi       <= max_lba[23:16];
            devhead[3:0] <= max_lba[27:24];
        end else if (op_set_max) begin
            secnum       <= `CHS_MAX_SECTOR;
            cyl_lo       <= max_cyl[7:0];
            cyl_hi       <= max_cyl[15:8];
            devhead[3:0] <= `CHS_MAX_HEAD;
        end else if (tf_wr) begin
            if (host_addr == `TF_SECNUM) begin
                secnum <= host_wdata;
            end
            if (host_addr == `TF_CYL_LO) begin
                cyl_lo <= host_wdata;
            end
            if (host_addr == `TF_CYL_HI) begin
                cyl_hi <= host_wdata;
            end
            if (host_addr == `TF_DEVHEAD) begin
                devhead <= host_wdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            block_size <= `BLOCK_RESET;
        end else if (op_set_mult) begin
            // take the count or disable on a bad size.
            block_size <= size_ok ? seccount[4:0] : `BLOCK_RESET;
        end
    end

    assign next_abort = (op_set_mult && !size_ok) || op_other || smart_bad;

    always_ff @(posedge clock) begin
        if (!nrst || soft_reset) begin
            abort_error_flag <= 1'b0;
        end else if (cmd_wr) begin
            abort_error_flag <= next_abort;
        end
    end

    // Set wins over clear so a completion in a status-read cycle still interrupts.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            intrq <= 1'b0;
        end else begin
            intrq <= irq_set || (intrq && !irq_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Attribute block transfer and host reads.

    // count the 256 words of one block.
    always_ff @(posedge clock) begin
        if (!nrst || state == st_work) begin
            word_count <= `BYTE_ZERO;
        end else if (data_pop) begin
            word_count <= word_count + 8'h01;
        end
    end

    sector_fifo #(
        .WIDTH (16),
        .DEPTH (16)
    ) u_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (attr_valid),
        .in_ready  (attr_ready),
        .in_data   (attr_data),
        .out_valid (fifo_valid),
        .out_ready (data_pop),
        .out_data  (fifo_data)
    );

    assign media_kind = (feature == `SUB_READ_THRESH);

    wire [7:0]  tf_byte = (host_addr == `TF_FEATURE)  ? error_reg :
                          (host_addr == `TF_SECCOUNT) ? seccount :
                          (host_addr == `TF_SECNUM)   ? secnum :
                          (host_addr == `TF_CYL_LO)   ? cyl_lo :
                          (host_addr == `TF_CYL_HI)   ? cyl_hi :
                          (host_addr == `TF_DEVHEAD)  ? devhead : status_reg;
    wire [15:0] rd_mux  = (sleeping || !dev_match) ? `WORD_ZERO :
                          (host_addr == `TF_DATA)     ? fifo_data : {`BYTE_ZERO, tf_byte};

    always_ff @(posedge clock) begin
        if (!nrst) begin
            host_rdata <= `WORD_ZERO;
        end else if (host_rd) begin
            host_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence flush_finishes;
        (state == st_flush) && flush_done;
    endsequence

    sequence media_finishes;
        (state == st_work) && media_done && !soft_reset;
    endsequence

    a_block_reset: assert property ($rose(nrst) |-> block_size == `BLOCK_RESET)
        else $error("block size not zero after reset");
    a_block_legal: assert property (block_size inside {`BLOCK_RESET, `BLOCK_2, `BLOCK_4, `BLOCK_8, `BLOCK_16})
        else $error("illegal block size held");
    a_block_take: assert property (op_set_mult && size_ok |=> block_size == $past(seccount[4:0])
        && !abort_error_flag && intrq) else $error("block size not taken");
    a_block_abort: assert property (op_set_mult && !size_ok && !soft_reset |=> abort_error_flag
        && !multiple_enabled) else $error("bad block size not aborted");
    a_lba_return: assert property (op_set_max && lba_mode |=> {devhead[3:0], cyl_hi, cyl_lo, secnum}
        == $past(max_lba)) else $error("max block address not returned");
    a_chs_return: assert property (op_set_max && !lba_mode |=> secnum == `CHS_MAX_SECTOR
        && devhead[3:0] == `CHS_MAX_HEAD && {cyl_hi, cyl_lo} == $past(max_cyl)) else $error("chs max wrong");
    a_sleep_entry: assert property ($rose(state == st_sleep) |-> $past(state == st_flush)
        || $past(state == st_spin)) else $error("sleep entered without sleep command");
    a_sleep_order: assert property (flush_finishes ##0 !soft_reset |=> intrq ##0
        (state == st_spin || state == st_sleep)) else $error("sleep did not interrupt after flush");
    a_sleep_skip: assert property (flush_finishes ##0 spun_down && !soft_reset |=> state == st_sleep
        && !spin_req) else $error("spin down not skipped");
    a_sleep_hold: assert property (sleeping && !soft_reset |=> sleeping)
        else $error("sleep left without reset");
    a_drive_other: assert property (host_wr && host_addr == `TF_COMMAND && !dev_match && idle
        && !soft_reset |=> idle && !$rose(intrq)) else $error("command for other drive acted on");
    a_read_start: assert property (smart_read && !soft_reset |=> busy && media_req)
        else $error("attribute read not started");
    a_read_steps: assert property (media_finishes |=> drq && !busy && intrq)
        else $error("read steps out of order");
    a_xfer_len: assert property (xfer_end && !soft_reset |=> idle && !drq)
        else $error("block transfer length wrong");

endmodule : ata_command_handler

`default_nettype wire

//--- hw/sector_fifo.sv
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module sector_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    wire [AW:0]       next_rd = rd_ptr + (AW+1)'(pop);

    // Extra pointer bit tells full from empty.
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);

    // Head word is registered; a word written into the slot read next is passed straight through.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            out_data <= '0;
        end else if (push && (wr_ptr[AW-1:0] == next_rd[AW-1:0])) begin
            out_data <= in_data;
        end else begin
            out_data <= mem[next_rd[AW-1:0]];
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end

endmodule : sector_fifo

`default_nettype wire

//--- testbench/ata_command_handler_test.sv
/* Self-checking bench of the command handler, acting as the host adapter.
   Assumes the design files and the media partner model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "ata_cmd_map.svh"

module ata_command_handler_test;
    import ata_cmd_pkg::*;
    logic clock = 1'b0, nrst = 1'b0, is_slave = 1'b0, host_wr = 1'b0, host_rd = 1'b0, soft_reset = 1'b0;
    reg_addr_t host_addr = 3'h0;
    logic [7:0] host_wdata = 8'h00, rb;
    logic [15:0] host_rdata, attr_data, rd_val, max_cyl = 16'h0000;
    logic [27:0] max_lba = 28'h0000000;
    logic intrq, multiple_enabled, flush_req, flush_done, spin_req, spun_down, seen;
    logic media_req, media_kind, media_done, attr_valid, attr_ready;
    logic [4:0] block_size;
    logic [7:0] codes [12] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hd7};
    logic [7:0] sizes [6] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h03};
    int fail_count = 0, compares = 0, word_next = 0;

    always #10 clock = ~clock;

    ata_command_handler u_dut (.clock(clock), .nrst(nrst), .is_slave(is_slave), .host_wr(host_wr),
        .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .soft_reset(soft_reset), .intrq(intrq), .multiple_enabled(multiple_enabled),
        .block_size(block_size), .flush_req(flush_req), .flush_done(flush_done), .spin_req(spin_req),
        .spun_down(spun_down), .media_req(media_req), .media_kind(media_kind), .media_done(media_done),
        .max_lba(max_lba), .max_cyl(max_cyl), .attr_valid(attr_valid), .attr_ready(attr_ready),
        .attr_data(attr_data));

    media_partner u_far (.clock(clock), .nrst(nrst), .flush_req(flush_req), .flush_done(flush_done),
        .spin_req(spin_req), .spun_down(spun_down), .media_req(media_req), .media_done(media_done),
        .attr_valid(attr_valid), .attr_ready(attr_ready), .attr_data(attr_data));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clock);
        host_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a);
        @(posedge clock);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clock);
        host_rd <= 1'b0;
        #1;
        rd_val = host_rdata;
        rb = rd_val[7:0];
    endtask : rd

    task automatic cmd(input logic [7:0] dh, input logic [7:0] op);
        wr(`TF_DEVHEAD, dh);
        wr(`TF_COMMAND, op);
    endtask : cmd

    task automatic wait_irq;
        int n;
        n = 0;
        while (intrq !== 1'b1 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("intrq raised", 16'h1, intrq);
    endtask : wait_irq

    task automatic t_block;
        for (int i = 0; i < 6; i++) begin
            wr(`TF_SECCOUNT, sizes[i]);
            cmd(8'ha0, `OP_SET_MULT);
            chk("intrq", 16'h1, intrq);
            chk("block size", (i < 5) ? sizes[i] : 8'h00, block_size);
            chk("multiple", (i > 0 && i < 5), multiple_enabled);
            rd(`TF_COMMAND);
            chk("status", (i < 5) ? 8'h50 : 8'h51, rb);
            chk("intrq cleared", 16'h0, intrq);
            rd(`TF_FEATURE);
            chk("error", (i < 5) ? 8'h00 : 8'h04, rb);
        end
        $display("test block size done");
    endtask : t_block

    task automatic t_setmax;
        @(posedge clock);
        max_lba <= 28'h9abcdef;
        max_cyl <= 16'h1234;
        cmd(8'he0, `OP_SET_MAX);
        chk("intrq", 16'h1, intrq);
        rd(`TF_SECNUM);
        chk("lba low", 16'h00ef, rb);
        rd(`TF_CYL_LO);
        chk("lba mid", 16'h00cd, rb);
        rd(`TF_CYL_HI);
        chk("lba high", 16'h00ab, rb);
        rd(`TF_DEVHEAD);
        chk("lba top", 16'h9, rb[3:0]);
        cmd(8'ha0, `OP_SET_MAX);
        chk("chs intrq", 16'h1, intrq);
        rd(`TF_SECNUM);
        chk("max sector", 16'h003f, rb);
        rd(`TF_CYL_LO);
        chk("cyl low", 16'h0034, rb);
        rd(`TF_CYL_HI);
        chk("cyl high", 16'h0012, rb);
        rd(`TF_DEVHEAD);
        chk("max head", 16'hf, rb[3:0]);
        rd(`TF_COMMAND);
        chk("set max status", 16'h0050, rb);
        chk("set max intrq cleared", 16'h0, intrq);
        $display("test set max done");
    endtask : t_setmax

    task automatic t_select;
        wr(`TF_SECCOUNT, 8'h02);
        cmd(8'hb0, `OP_SET_MULT);
        chk("other drive", 16'h0, {intrq, block_size});
        @(posedge clock);
        is_slave <= 1'b1;
        cmd(8'hb0, `OP_SET_MULT);
        chk("slave size", 16'h2, block_size);
        @(posedge clock);
        is_slave <= 1'b0;
        $display("test drive select done");
    endtask : t_select

    task automatic t_smart;
        chk("fifo full", 16'h0, attr_ready);
        for (int i = 0; i < 13; i++) begin
            wr(`TF_CYL_LO, (i < 12) ? `SMART_KEY_LO : 8'h00);
            wr(`TF_CYL_HI, `SMART_KEY_HI);
            wr(`TF_FEATURE, (i < 12) ? codes[i] : 8'hd8);
            cmd(8'ha0, `OP_SMART);
            if (i < 2) begin
                chk("media req", {i[0], 1'b1, 1'b0}, {media_kind, media_req, intrq});
                wait_irq();
                rd(`TF_COMMAND);
                chk("drq status", 16'h0058, rb);
                repeat (256) begin
                    rd(`TF_DATA);
                    chk("attr word", word_next[15:0], rd_val);
                    word_next++;
                end
            end
            chk("intrq", (i < 2) ? 16'h0 : 16'h1, intrq);
            rd(`TF_COMMAND);
            chk("status", (i == 5 || i == 6 || i > 10) ? 8'h51 : 8'h50, rb);
        end
        $display("test monitoring done");
    endtask : t_smart

    task automatic t_sleep(input logic [7:0] op, input logic down);
        seen = 1'b0;
        cmd(8'ha0, op);
        repeat (3) @(posedge clock);
        #1;
        chk("flush first", 16'h2, {flush_req, intrq});
        wait_irq();
        repeat (20) begin
            @(posedge clock);
            #1;
            seen = seen | spin_req;
        end
        chk("spin request", !down, seen);
        chk("spun down", 16'h1, spun_down);
        rd(`TF_COMMAND);
        chk("asleep", 16'h0, rb);
        cmd(8'ha0, `OP_SET_MULT);
        chk("write ignored", 16'h0, {intrq, flush_req});
        @(posedge clock);
        soft_reset <= 1'b1;
        @(posedge clock);
        soft_reset <= 1'b0;
        rd(`TF_COMMAND);
        chk("awake", 16'h0050, rb);
        $display("test sleep done");
    endtask : t_sleep

    task automatic conclude;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1;
        chk("reset state", 16'h0, {intrq, multiple_enabled, block_size});
        t_block();
        t_setmax();
        t_select();
        t_smart();
        t_sleep(`OP_SLEEP_A, 1'b0);
        t_sleep(`OP_SLEEP_B, 1'b1);
        conclude();
    end
endmodule : ata_command_handler_test
`default_nettype wire

//--- testbench/media_partner.sv
/* Model of the drive mechanics behind the handler: cache flush, spindle and attribute source.
   Assumes one clock and a synchronous active-low reset shared with the handler. */
`timescale 1ns/10ps
`default_nettype none

module media_partner (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        flush_req,
    output logic             flush_done,
    input  wire logic        spin_req,
    output logic             spun_down,
    input  wire logic        media_req,
    output logic             media_done,
    output logic             attr_valid,
    input  wire logic        attr_ready,
    output logic      [15:0] attr_data
);
    logic [3:0] cnt;

    // Every request is answered after a few cycles, so the handler must wait.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt        <= 4'h0;
            flush_done <= 1'b0;
            spun_down  <= 1'b0;
            media_done <= 1'b0;
            attr_data  <= 16'h0000;
        end else begin
            cnt        <= (flush_req | spin_req | media_req) ? cnt + 4'h1 : 4'h0;
            flush_done <= flush_req && cnt == 4'h4;
            media_done <= media_req && cnt == 4'h4;
            if (spin_req && cnt == 4'h4) begin
                spun_down <= 1'b1;
            end
            if (attr_ready) begin
                attr_data <= attr_data + 16'h0001;
            end
        end
    end

    // The attribute source offers a counting word whenever it is out of reset.
    assign attr_valid = nrst;
endmodule : media_partner
`default_nettype wire
